// >>> logic/vid_reference_tracker_params.svh
// Timing counts, field positions and decode constants for the voltage id tracker.
// Assumes a 250 MHz system clock and an outside code source that meets the stated pacing.
//
// Operation
// - Code pins are sampled on each rising edge of a 3 MHz sample tick, all modes.
// - A changed code is accepted after three identical consecutive samples.
// - Direct-step modes set the reference to the decoded level at once on acceptance.
// - Slewing modes accept multi-step code changes under the same stability check.
// - Slewing modes step the reference by 6.25 mV at 330 kHz until it meets target.
// - Six-bit decode: 25 mV per code below 100000, then 12.5 mV per code.
// - In five-bit slewing mode an all-ones code blocks the start-up ramp.
`ifndef VID_REFERENCE_TRACKER_PARAMS_SVH
`define VID_REFERENCE_TRACKER_PARAMS_SVH

// ==========================================================================
// Clock rates and derived counts
// ==========================================================================
`define SYS_CLK_KHZ 250000
`define SAMPLE_CLK_KHZ 3000
`define SAMPLE_DIV (`SYS_CLK_KHZ / `SAMPLE_CLK_KHZ)
`define STEP_RATE_KHZ 330
`define STEP_DIV (`SYS_CLK_KHZ / `STEP_RATE_KHZ)
`define DIRECT_MIN_BIT_TIME_NS 2000
`define STABLE_READS 3

// ==========================================================================
// Level encoding: one level unit is one slew step
// ==========================================================================
`define SLEW_STEP_UV 6250
`define LEVEL_W 9
`define CODE_W 8
`define LEVEL_RESET 9'h000
`define LEVEL_OFF 9'h000
`define LEVEL_DIRECT_TOP 9'h102
`define LEVEL_WIDE_TOP 9'h0F8
`define LEVEL_FINE_TOP 9'h07A
`define CODE_DIRECT_OFF_LO 8'h01
`define CODE_DIRECT_OFF_HI 8'hFE
`define CODE_5BIT_OFF 5'h1F
`define CODE_6BIT_FINE_BIT 5

`endif

// >>> logic/vid_reference_tracker_pkg.sv
// Types shared by the voltage id tracker and its level decoder.
// Assumes the constants header is compiled alongside it.
`default_nettype none
package vid_reference_tracker_pkg;

    // ======================================================================
    // Operating modes of the code interface
    // ======================================================================
    typedef enum logic [1:0] {
        DIRECT_STEP_MODE_A,
        DIRECT_STEP_MODE_B,
        SLEW_MODE_5BIT,
        SLEW_MODE_6BIT
    } mode_t;

    typedef logic [8:0] level_t;
    typedef logic [7:0] code_t;

endpackage
`default_nettype wire

// >>> logic/vid_level_decoder.sv
// Combinational decode of a voltage id code into a reference level.
// Assumes the level unit is one 6.25 mV step and the code is already stable.
`include "vid_reference_tracker_params.svh"
`default_nettype none
module vid_level_decoder
    import vid_reference_tracker_pkg::*;
(
    input wire code_t code,
    input wire mode_t mode,
    output level_t level,
    output logic code_off
);

    // ======================================================================
    // Decode functions
    // ======================================================================

    // Eight-bit table: one step per code counting down from the top level.
    function automatic level_t decode_direct(input code_t c);
        decode_direct = `LEVEL_DIRECT_TOP - level_t'({1'b0, c});
    endfunction

    // Six-bit table: four steps per code below 100000, two per code from 100000 up.
    function automatic level_t decode_six(input logic [5:0] c);
        if (c[`CODE_6BIT_FINE_BIT]) begin
            decode_six = `LEVEL_FINE_TOP - level_t'({c[4:0], 1'b0});
        end else begin
            decode_six = `LEVEL_WIDE_TOP - level_t'({c[4:0], 2'b00});
        end
    endfunction

    // Select the table for the mode and flag codes that turn the output off.
    always_comb begin
        level = `LEVEL_OFF;
        code_off = 1'b0;
        unique case (mode)
            DIRECT_STEP_MODE_A, DIRECT_STEP_MODE_B: begin
                if (code <= `CODE_DIRECT_OFF_LO || code >= `CODE_DIRECT_OFF_HI) begin
                    code_off = 1'b1;
                end else begin
                    level = decode_direct(code);
                end
            end
            SLEW_MODE_5BIT: begin
                if (code[4:0] == `CODE_5BIT_OFF) begin
                    code_off = 1'b1;
                end else begin
                    level = decode_six({1'b0, code[4:0]});
                end
            end
            SLEW_MODE_6BIT: begin
                level = decode_six(code[5:0]);
            end
        endcase
    end

endmodule
`default_nettype wire

// >>> logic/vid_reference_tracker.sv
// Voltage id tracker: filters the code pins and drives the internal reference level.
// Assumes code and mode pins are asynchronous to SYS_CLK and are resynchronised here.
`include "vid_reference_tracker_params.svh"
`default_nettype none
module vid_reference_tracker
    import vid_reference_tracker_pkg::*;
#(
    parameter int STABLE_READS = `STABLE_READS,
    parameter int SAMPLE_DIV = `SAMPLE_DIV,
    parameter int STEP_DIV = `STEP_DIV
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] VOLTAGE_ID_CODE,
    input wire logic [1:0] MODE_SELECT,
    output logic [8:0] DAC_REFERENCE_LEVEL,
    output logic [8:0] TARGET_LEVEL,
    output logic CODE_ACCEPTED,
    output logic CODE_VALID,
    output logic CODE_OFF,
    output logic SLEWING,
    output logic NO_LOAD,
    output logic START_PERMIT
);

    // ======================================================================
    // State record
    // ======================================================================
    typedef struct packed {
        code_t code_s1;
        code_t code_s2;
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        logic [6:0] sample_cnt;
        logic [9:0] step_cnt;
        code_t candidate;
        logic [1:0] match_cnt;
        code_t accepted;
        logic accepted_valid;
        logic accept_pulse;
        level_t dac;
        level_t target;
        logic off;
        logic slewing;
        logic no_load;
        logic permit;
    } tracker_state_t;

    tracker_state_t state_reg;
    tracker_state_t state_next;
    mode_t mode_now;
    level_t dec_level;
    logic dec_off;
    logic sample_tick;
    logic step_tick;
    logic slew_mode;

    assign mode_now = mode_t'(state_reg.mode_s2);
    assign slew_mode = (mode_now == SLEW_MODE_5BIT) || (mode_now == SLEW_MODE_6BIT);
    assign sample_tick = (state_reg.sample_cnt == 7'(SAMPLE_DIV - 1));
    assign step_tick = (state_reg.step_cnt == 10'(STEP_DIV - 1));

    // ======================================================================
    // Decoder of the accepted code
    // ======================================================================

    // The decoder always looks at the held code, never at a code still settling.
    vid_level_decoder u_decoder (
        .code(state_reg.accepted),
        .mode(mode_now),
        .level(dec_level),
        .code_off(dec_off)
    );

    // ======================================================================
    // Next-state logic
    // ======================================================================

    // Synchronise pins, filter the code, then move the reference level.
    always_comb begin
        state_next = state_reg;
        state_next.accept_pulse = 1'b0;
        // Two flops on every code and mode pin before anything reads it.
        state_next.code_s1 = VOLTAGE_ID_CODE;
        state_next.code_s2 = state_reg.code_s1;
        state_next.mode_s1 = MODE_SELECT;
        state_next.mode_s2 = state_reg.mode_s1;
        // Free-running 3 MHz sample divider.
        state_next.sample_cnt = sample_tick ? 7'h00 : state_reg.sample_cnt + 7'h01;
        state_next.step_cnt = step_tick ? 10'h000 : state_reg.step_cnt + 10'h001;
        if (sample_tick) begin
            if (state_reg.code_s2 != state_reg.candidate) begin
                // A differing reading restarts the count; the held code stays.
                state_next.candidate = state_reg.code_s2;
                state_next.match_cnt = 2'h1;
            end else if (32'(state_reg.match_cnt) < STABLE_READS) begin
                state_next.match_cnt = state_reg.match_cnt + 2'h1;
            end
            // Accept once the same value has been read enough times in a row.
            if (state_reg.code_s2 == state_reg.candidate && 32'(state_reg.match_cnt) + 1 >= STABLE_READS
                && (!state_reg.accepted_valid || state_reg.accepted != state_reg.candidate)) begin
                state_next.accepted = state_reg.candidate;
                state_next.accepted_valid = 1'b1;
                state_next.accept_pulse = 1'b1;
            end
        end
        // The target follows the decode of the held code, any step size allowed.
        state_next.target = state_reg.accepted_valid ? dec_level : `LEVEL_RESET;
        state_next.off = state_reg.accepted_valid && dec_off;
        if (!slew_mode) begin
            // Direct-step modes jump straight to the decoded level.
            state_next.dac = state_reg.target;
        end else if (step_tick && state_reg.dac != state_reg.target) begin
            // Slewing modes move one 6.25 mV unit per 330 kHz step.
            if (state_reg.dac < state_reg.target) begin
                state_next.dac = state_reg.dac + 9'h001;
            end else begin
                state_next.dac = state_reg.dac - 9'h001;
            end
        end
        state_next.slewing = slew_mode && (state_reg.dac != state_reg.target);
        // An all-ones five-bit code means no load and holds off start-up.
        state_next.no_load = (mode_now == SLEW_MODE_5BIT) && state_reg.accepted_valid && dec_off;
        state_next.permit = state_reg.accepted_valid
            && !((mode_now == SLEW_MODE_5BIT) && dec_off);
    end

    // ======================================================================
    // State register
    // ======================================================================

    // Synchronous reset to a known idle state with the reference at zero.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register.
    assign DAC_REFERENCE_LEVEL = state_reg.dac;
    assign TARGET_LEVEL = state_reg.target;
    assign CODE_ACCEPTED = state_reg.accept_pulse;
    assign CODE_VALID = state_reg.accepted_valid;
    assign CODE_OFF = state_reg.off;
    assign SLEWING = state_reg.slewing;
    assign NO_LOAD = state_reg.no_load;
    assign START_PERMIT = state_reg.permit;

endmodule
`default_nettype wire

// >>> tb/vid_reference_tracker_properties.sv
// Port assertions for the voltage id tracker.
// Assumes it is bound to the tracker top with the same divider values.
`default_nettype none
module vid_tracker_checker #(
    parameter int SAMPLE_DIV = 4,
    parameter int STEP_DIV = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] VOLTAGE_ID_CODE,
    input wire logic [1:0] MODE_SELECT,
    input wire logic [8:0] DAC_REFERENCE_LEVEL,
    input wire logic [8:0] TARGET_LEVEL,
    input wire logic CODE_ACCEPTED,
    input wire logic CODE_VALID,
    input wire logic CODE_OFF,
    input wire logic SLEWING,
    input wire logic NO_LOAD,
    input wire logic START_PERMIT
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Helper counters and properties
    // ==========================================
    logic [7:0] last_code_reg;
    logic [15:0] calm_reg;
    logic [15:0] idle_reg;
    // Count cycles since the code pins moved and since the last slew step.
    always_ff @(posedge SYS_CLK) begin
        last_code_reg <= VOLTAGE_ID_CODE;
        if (RST) begin
            calm_reg <= 16'h0000;
            idle_reg <= 16'h0000;
        end else begin
            calm_reg <= (VOLTAGE_ID_CODE != last_code_reg) ? 16'h0000 : calm_reg + 16'h0001;
            idle_reg <= ($changed(DAC_REFERENCE_LEVEL) || !SLEWING) ? 16'h0000 : idle_reg + 16'h0001;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // A direct-mode accept lands on the reference two cycles later.
    sequence direct_accept_s;
        CODE_ACCEPTED && !MODE_SELECT[1];
    endsequence
    sequence lands_s;
        ##2 DAC_REFERENCE_LEVEL == TARGET_LEVEL;
    endsequence
    direct_jump_a: assert property (direct_accept_s |-> lands_s)
        else $error("direct reference did not jump");
    pulse_once_a: assert property (CODE_ACCEPTED |=> !CODE_ACCEPTED && CODE_VALID)
        else $error("accept pulse wrong");
    accept_filter_a: assert property (CODE_ACCEPTED |-> calm_reg >= 2 * SAMPLE_DIV)
        else $error("code accepted too early");
    target_hold_a: assert property ($changed(TARGET_LEVEL) |-> $past(CODE_ACCEPTED))
        else $error("target moved without accept");
    slew_unit_a: assert property (MODE_SELECT[1] && $changed(DAC_REFERENCE_LEVEL) |->
        (DAC_REFERENCE_LEVEL == $past(DAC_REFERENCE_LEVEL) + 9'h001) ||
        (DAC_REFERENCE_LEVEL + 9'h001 == $past(DAC_REFERENCE_LEVEL))) else $error("slew step not one unit");
    step_rate_a: assert property (idle_reg <= STEP_DIV)
        else $error("slew stalled");
    slew_stop_a: assert property ($stable(TARGET_LEVEL) &&
        $past(DAC_REFERENCE_LEVEL) == $past(TARGET_LEVEL) |-> $stable(DAC_REFERENCE_LEVEL))
        else $error("reference left target");
    no_load_a: assert property (NO_LOAD |-> !START_PERMIT && CODE_VALID)
        else $error("start allowed with no load");
    off_level_a: assert property (CODE_OFF |-> TARGET_LEVEL == 9'h000)
        else $error("off code with nonzero target");
endmodule
`default_nettype wire

// >>> tb/vid_processor_model.sv
// Processor model that drives the voltage id code pins.
// Assumes want and direct change just after a rising clock edge.
`default_nettype none
module vid_processor_model
    import vid_reference_tracker_pkg::*;
#(
    parameter int HOLD = 24
) (
    input wire logic clk,
    input wire code_t want,
    input wire logic direct,
    output var code_t code
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Code sequencing
    // ==========================================
    int pace_reg = 0;
    // Direct modes walk one code per hold time, scaled to the short divider.
    always @(posedge clk) begin
        pace_reg <= (pace_reg >= HOLD - 1) ? 0 : pace_reg + 1;
        if (!direct) begin
            code <= want;
        end else if (pace_reg == 0 && code != want) begin
            code <= (code < want) ? code + 8'h01 : code - 8'h01;
        end
    end
    // The pins start low.
    initial code = 8'h00;
endmodule
`default_nettype wire

// >>> tb/test_vid_reference_tracker.sv
// Self-checking bench for the voltage id tracker with a processor model.
// Assumes shortened dividers so every slew ends within a few thousand cycles.
`default_nettype none
module test_vid_reference_tracker
    import vid_reference_tracker_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals, design, partner and tasks
    // ==========================================
    typedef struct packed {mode_t m; code_t c; level_t l;} row_t;
    logic SYS_CLK = 1'b0;
    logic RST;
    mode_t mode;
    code_t want;
    code_t code;
    level_t DAC_REFERENCE_LEVEL;
    level_t TARGET_LEVEL;
    logic CODE_ACCEPTED, CODE_VALID, CODE_OFF, SLEWING, NO_LOAD, START_PERMIT, seen;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    row_t rows[8] = '{'{DIRECT_STEP_MODE_A, 8'h02, 9'h100}, '{DIRECT_STEP_MODE_A, 8'h03, 9'h0FF},
        '{DIRECT_STEP_MODE_B, 8'h04, 9'h0FE}, '{DIRECT_STEP_MODE_B, 8'h01, 9'h000},
        '{SLEW_MODE_6BIT, 8'h00, 9'h0F8}, '{SLEW_MODE_6BIT, 8'h1F, 9'h07C},
        '{SLEW_MODE_6BIT, 8'h20, 9'h07A}, '{SLEW_MODE_6BIT, 8'h3F, 9'h03C}};
    vid_reference_tracker #(.STABLE_READS(3), .SAMPLE_DIV(4), .STEP_DIV(8)) i_dut (
        .SYS_CLK, .RST, .VOLTAGE_ID_CODE(code), .MODE_SELECT(mode), .DAC_REFERENCE_LEVEL, .TARGET_LEVEL,
        .CODE_ACCEPTED, .CODE_VALID, .CODE_OFF, .SLEWING, .NO_LOAD, .START_PERMIT);
    vid_processor_model #(.HOLD(24)) i_cpu (.clk(SYS_CLK), .want(want), .direct(!mode[1]), .code(code));
    // The clock runs at 250 MHz and a hung run is cut short.
    always #2 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // Shared steps, compares and the closing report.
    task automatic tick;
        @(posedge SYS_CLK);
        #1;
    endtask
    task automatic check_level(input string what, input level_t exp, input level_t got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic pulse_reset(input mode_t m);
        @(posedge SYS_CLK);
        RST <= 1'b1;
        mode <= m;
        repeat (4) @(posedge SYS_CLK);
        RST <= 1'b0;
    endtask
    task automatic apply(input mode_t m, input code_t c);
        if (m != mode) begin
            pulse_reset(m);
            while (CODE_ACCEPTED !== 1'b1) tick;
        end
        @(posedge SYS_CLK);
        want <= c;
        tick;
        while (code !== c) tick;
        while (CODE_ACCEPTED !== 1'b1) tick;
        repeat (3) tick;
        while (SLEWING !== 1'b0 || DAC_REFERENCE_LEVEL !== TARGET_LEVEL) tick;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence: reset, table rows, a glitch, no-load and a second reset.
    initial begin
        RST = 1'b1;
        mode = DIRECT_STEP_MODE_A;
        want = 8'h00;
        repeat (4) @(posedge SYS_CLK);
        RST <= 1'b0;
        tick;
        check_level("reset reference", 9'h000, DAC_REFERENCE_LEVEL);
        $display("reset test done");
        foreach (rows[i]) begin
            apply(rows[i].m, rows[i].c);
            check_level("target", rows[i].l, TARGET_LEVEL);
            check_level("reference", rows[i].l, DAC_REFERENCE_LEVEL);
            check_bit("off", rows[i].l == 9'h000, CODE_OFF);
            $display("row %0d done", i);
        end
        @(posedge SYS_CLK);
        want <= 8'h10;
        repeat (5) @(posedge SYS_CLK);
        want <= 8'h3F;
        seen = 1'b0;
        repeat (40) begin
            tick;
            seen = seen | CODE_ACCEPTED;
        end
        check_bit("glitch accept", 1'b0, seen);
        check_level("held target", 9'h03C, TARGET_LEVEL);
        $display("glitch test done");
        apply(SLEW_MODE_5BIT, 8'h1E);
        check_bit("permit", 1'b1, START_PERMIT);
        apply(SLEW_MODE_5BIT, 8'h1F);
        check_bit("no load", 1'b1, NO_LOAD);
        check_bit("permit", 1'b0, START_PERMIT);
        $display("no load test done");
        pulse_reset(mode);
        tick;
        check_bit("valid after reset", 1'b0, CODE_VALID);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
bind vid_reference_tracker vid_tracker_checker #(.SAMPLE_DIV(SAMPLE_DIV), .STEP_DIV(STEP_DIV)) i_checker (
    .SYS_CLK, .RST, .VOLTAGE_ID_CODE, .MODE_SELECT, .DAC_REFERENCE_LEVEL, .TARGET_LEVEL,
    .CODE_ACCEPTED, .CODE_VALID, .CODE_OFF, .SLEWING, .NO_LOAD, .START_PERMIT);
`default_nettype wire
